// ===== logic/icwl_loader.sv
// Purpose: indirect 8-bit host write port building 32-bit control words
// Assumes: host pins and domain clocks are asynchronous to clock
// Notes:   domain clocks are sampled and their edges counted
`timescale 1ns/1ps
`default_nettype none
`include "icwl_params.svh"

module icwl_loader (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // host write port
    input  wire logic [7:0]  host_data_bus,
    input  wire logic [2:0]  host_addr,
    input  wire logic        write_strobe,
    // destination domain clocks
    input  wire logic        front_end_clock,
    input  wire logic        back_end_clock,
    // system sync events
    input  wire logic        carrier_sync_in,
    input  wire logic        gain_sync_in,
    // destination load
    output logic      [7:0]  dest_addr,
    output logic      [31:0] dest_word,
    output logic             front_load,
    output logic             back_load,
    // active gain
    output logic      [31:0] gain_active,
    output logic             gain_load,
    // active carrier frequency
    output logic      [31:0] carrier_active,
    output logic             carrier_load,
    // read source
    output logic      [2:0]  read_source
);
    import icwl_pkg::*;

    // ==========================================================
    // decode helpers
    function automatic logic is_front(input logic [7:0] addr);
        is_front = (addr <= `ICWL_FRONT_TOP);
    endfunction : is_front

    function automatic logic [31:0] pack_word(input icwl_bytes_t b);
        pack_word = {b[3], b[2], b[1], b[0]};
    endfunction : pack_word

    // ==========================================================
    // declarations
    logic [15:0]  sync_q;
    logic         s_strobe;
    logic [2:0]   s_addr;
    logic [7:0]   s_data;
    logic         s_front;
    logic         s_back;
    logic         s_carrier;
    logic         s_gain;

    logic         prev_strobe;
    logic         prev_front;
    logic         prev_back;
    logic         prev_carrier;
    logic         prev_gain;
    logic         strobe_rise;
    logic         front_rise;
    logic         back_rise;
    logic         carrier_rise;
    logic         gain_rise;

    icwl_bytes_t  holding;
    icwl_bytes_t  next_holding;
    logic [7:0]   target;
    logic [7:0]   next_target;
    logic [2:0]   next_read_source;
    logic         target_write;
    logic         next_target_write;

    logic         front_start;
    logic         back_start;
    logic         front_done;
    logic         back_done;

    logic [7:0]   next_dest_addr;
    logic [31:0]  next_dest_word;
    logic         next_front_load;
    logic         next_back_load;
    logic         carrier_mode;
    logic         next_carrier_mode;
    logic         gain_mode;
    logic         next_gain_mode;
    logic [31:0]  carrier_hold;
    logic [31:0]  next_carrier_hold;
    logic [31:0]  next_gain_active;
    logic         next_gain_load;
    logic [31:0]  next_carrier_active;
    logic         next_carrier_load;
    logic         any_done;
    logic [31:0]  word_now;

    // ==========================================================
    // pin synchronisers
    icwl_sync2 #(
        .WIDTH (16)
    ) u_sync (
        .clock (clock),
        .rstn  (rstn),
        .pin   ({write_strobe, host_addr, host_data_bus, front_end_clock,
                 back_end_clock, carrier_sync_in, gain_sync_in}),
        .sync  (sync_q)
    );

    assign s_strobe  = sync_q[15];
    assign s_addr    = sync_q[14:12];
    assign s_data    = sync_q[11:4];
    assign s_front   = sync_q[3];
    assign s_back    = sync_q[2];
    assign s_carrier = sync_q[1];
    assign s_gain    = sync_q[0];

    // ==========================================================
    // edge history
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            prev_strobe  <= 1'b0;
            prev_front   <= 1'b0;
            prev_back    <= 1'b0;
            prev_carrier <= 1'b0;
            prev_gain    <= 1'b0;
        end
        else
        begin
            prev_strobe  <= s_strobe;
            prev_front   <= s_front;
            prev_back    <= s_back;
            prev_carrier <= s_carrier;
            prev_gain    <= s_gain;
        end
    end

    assign strobe_rise  = s_strobe & ~prev_strobe;
    assign front_rise   = s_front & ~prev_front;
    assign back_rise    = s_back & ~prev_back;
    assign carrier_rise = s_carrier & ~prev_carrier;
    assign gain_rise    = s_gain & ~prev_gain;

    // ==========================================================
    // host holding registers
    always_comb
    begin
        next_holding      = holding;
        next_target       = target;
        next_read_source  = read_source;
        next_target_write = 1'b0;
        if (strobe_rise)
        begin
            unique case (s_addr)
                `ICWL_ADDR_BYTE0:
                begin
                    next_holding[0] = s_data;
                end
                `ICWL_ADDR_BYTE1:
                begin
                    next_holding[1] = s_data;
                end
                `ICWL_ADDR_BYTE2:
                begin
                    next_holding[2] = s_data;
                end
                `ICWL_ADDR_BYTE3:
                begin
                    next_holding[3] = s_data;
                end
                `ICWL_ADDR_TARGET:
                begin
                    next_target       = s_data;
                    next_target_write = 1'b1;
                end
                `ICWL_ADDR_RDSEL:
                begin
                    next_read_source = s_data[2:0];
                end
                default:
                begin
                    // addresses 6 and 7 are ignored
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            holding      <= {4{`ICWL_BYTE_RESET}};
            target       <= `ICWL_BYTE_RESET;
            read_source  <= `ICWL_RDSEL_RESET;
            target_write <= 1'b0;
        end
        else
        begin
            holding      <= next_holding;
            target       <= next_target;
            read_source  <= next_read_source;
            target_write <= next_target_write;
        end
    end

    // ==========================================================
    // transfer sequencers, one per destination clock
    assign front_start = target_write & is_front(target);
    assign back_start  = target_write & ~is_front(target);

    icwl_xfer u_front (
        .clock    (clock),
        .rstn     (rstn),
        .start    (front_start),
        .dom_rise (front_rise),
        .done     (front_done)
    );

    icwl_xfer u_back (
        .clock    (clock),
        .rstn     (rstn),
        .start    (back_start),
        .dom_rise (back_rise),
        .done     (back_done)
    );

    // ==========================================================
    // destination load, gain and carrier transfer
    assign any_done = front_done | back_done;
    assign word_now = pack_word(holding);

    always_comb
    begin
        next_dest_addr      = dest_addr;
        next_dest_word      = dest_word;
        next_front_load     = front_done;
        next_back_load      = back_done;
        next_carrier_mode   = carrier_mode;
        next_gain_mode      = gain_mode;
        next_carrier_hold   = carrier_hold;
        next_gain_active    = gain_active;
        next_gain_load      = 1'b0;
        next_carrier_active = carrier_active;
        next_carrier_load   = 1'b0;
        if (any_done)
        begin
            next_dest_addr = target;
            next_dest_word = word_now;
            if (target == `ICWL_CW0_ADDR)
            begin
                next_carrier_mode = word_now[`ICWL_CARRIER_SYNC_BIT];
            end
            if (target == `ICWL_CW8_ADDR)
            begin
                next_gain_mode = word_now[`ICWL_GAIN_SYNC_BIT];
            end
            if (target == `ICWL_CARRIER_HOLD)
            begin
                next_carrier_hold = word_now;
                if (!carrier_mode)
                begin
                    next_carrier_active = word_now;
                    next_carrier_load   = 1'b1;
                end
            end
            if ((target == `ICWL_GAIN_ADDR) && !gain_mode)
            begin
                next_gain_active = word_now;
                next_gain_load   = 1'b1;
            end
        end
        if (gain_mode && gain_rise)
        begin
            next_gain_active = word_now;
            next_gain_load   = 1'b1;
        end
        if (carrier_mode && carrier_rise)
        begin
            next_carrier_active = carrier_hold;
            next_carrier_load   = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            dest_addr      <= `ICWL_BYTE_RESET;
            dest_word      <= `ICWL_WORD_RESET;
            front_load     <= 1'b0;
            back_load      <= 1'b0;
            carrier_mode   <= 1'b0;
            gain_mode      <= 1'b0;
            carrier_hold   <= `ICWL_WORD_RESET;
            gain_active    <= `ICWL_WORD_RESET;
            gain_load      <= 1'b0;
            carrier_active <= `ICWL_WORD_RESET;
            carrier_load   <= 1'b0;
        end
        else
        begin
            dest_addr      <= next_dest_addr;
            dest_word      <= next_dest_word;
            front_load     <= next_front_load;
            back_load      <= next_back_load;
            carrier_mode   <= next_carrier_mode;
            gain_mode      <= next_gain_mode;
            carrier_hold   <= next_carrier_hold;
            gain_active    <= next_gain_active;
            gain_load      <= next_gain_load;
            carrier_active <= next_carrier_active;
            carrier_load   <= next_carrier_load;
        end
    end

endmodule : icwl_loader

`default_nettype wire

// ===== logic/icwl_params.svh
// Purpose: constants of the indirect control word loader
// Assumes: included by its bare name from the loader files
// Notes:   offsets, field positions, reset values and timing counts
`ifndef ICWL_PARAMS_SVH
`define ICWL_PARAMS_SVH

// ==========================================================
// host address map
`define ICWL_ADDR_BYTE0       3'h0
`define ICWL_ADDR_BYTE1       3'h1
`define ICWL_ADDR_BYTE2       3'h2
`define ICWL_ADDR_BYTE3       3'h3
`define ICWL_ADDR_TARGET      3'h4
`define ICWL_ADDR_RDSEL       3'h5

// ==========================================================
// destination map
`define ICWL_FRONT_TOP        8'h0f
`define ICWL_CW0_ADDR         8'h00
`define ICWL_CW8_ADDR         8'h08
`define ICWL_CARRIER_HOLD     8'h01
`define ICWL_GAIN_ADDR        8'h0b
`define ICWL_CARRIER_SYNC_BIT 20
`define ICWL_GAIN_SYNC_BIT    29

// ==========================================================
// reset values and timing
`define ICWL_WORD_RESET       32'h0000_0000
`define ICWL_BYTE_RESET       8'h00
`define ICWL_RDSEL_RESET      3'h0
`define ICWL_LOAD_CLOCKS      3'h4

`endif

// ===== logic/icwl_pkg.sv
// Purpose: types of the indirect control word loader
// Assumes: nothing
// Notes:   one-hot state codes
package icwl_pkg;

    // ==========================================================
    // transfer sequencer states
    typedef enum logic [1:0] {
        xs_idle = 2'b01,
        xs_wait = 2'b10
    } icwl_xstate_t;

    // ==========================================================
    // word assembled from the four holding bytes
    typedef logic [3:0][7:0] icwl_bytes_t;

endpackage : icwl_pkg

// ===== logic/icwl_sync2.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to clock
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none

module icwl_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rstn,
    // pins in, synchronised out
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] sync
);

    logic [WIDTH-1:0] stage1;

    // ==========================================================
    // two stages
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            stage1 <= '0;
            sync   <= '0;
        end
        else
        begin
            stage1 <= pin;
            sync   <= stage1;
        end
    end

endmodule : icwl_sync2

`default_nettype wire

// ===== logic/icwl_xfer.sv
// Purpose: counts domain clocks after a destination write
// Assumes: dom_rise marks one rising edge of the domain clock
// Notes:   done is a one-cycle registered pulse
`timescale 1ns/1ps
`default_nettype none
`include "icwl_params.svh"

module icwl_xfer (
    // clock and reset
    input  wire logic clock,
    input  wire logic rstn,
    // request and domain edge
    input  wire logic start,
    input  wire logic dom_rise,
    // transfer moment
    output logic      done
);
    import icwl_pkg::*;

    icwl_xstate_t state;
    icwl_xstate_t next_state;
    logic [2:0]   count;
    logic [2:0]   next_count;
    logic         next_done;

    // ==========================================================
    // sequencer
    always_comb
    begin
        next_state = state;
        next_count = count;
        next_done  = 1'b0;
        unique case (state)
            xs_idle:
            begin
                if (start)
                begin
                    next_state = xs_wait;
                    next_count = 3'h0;
                end
            end
            xs_wait:
            begin
                if (start)
                begin
                    next_count = 3'h0;
                end
                else if (dom_rise)
                begin
                    next_count = count + 3'h1;
                    if (count == `ICWL_LOAD_CLOCKS - 3'h1)
                    begin
                        next_done  = 1'b1;
                        next_state = xs_idle;
                    end
                end
            end
            default:
            begin
                next_state = xs_idle;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= xs_idle;
            count <= 3'h0;
            done  <= 1'b0;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
            done  <= next_done;
        end
    end

endmodule : icwl_xfer

`default_nettype wire

// ===== verification/icwl_host_model.sv
// Purpose: host processor model on the byte write port
// Assumes: clock is the system clock
// Notes:   data bus shows the inverse once its hold time is over
`timescale 1ns/1ps
`default_nettype none

module icwl_host_model (
    // clock
    input  wire logic       clock,
    // host pins
    output logic      [7:0] host_data_bus,
    output logic      [2:0] host_addr,
    output logic            write_strobe
);
    initial
    begin
        host_data_bus = 8'h00;
        host_addr     = 3'h7;
        write_strobe  = 1'b0;
    end

    // one write, 4 clocks of setup and hold around the strobe rise
    // bus shows the inverse from the strobe fall, so a fall capture fails
    task automatic write(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        host_addr     <= a;
        host_data_bus <= d;
        repeat (4) @(posedge clock);
        write_strobe  <= 1'b1;
        repeat (4) @(posedge clock);
        write_strobe  <= 1'b0;
        host_addr     <= ~a;
        host_data_bus <= ~d;
        repeat (4) @(posedge clock);
    endtask : write

endmodule : icwl_host_model

`default_nettype wire

// ===== verification/icwl_loader_chk.sv
// Purpose: checker bound to the control word loader ports
// Assumes: one clock domain, rstn active low
// Notes:   fe_age counts clocks since a front domain clock rise
`timescale 1ns/1ps
`default_nettype none

module icwl_loader_chk (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // host pins
    input  wire logic [7:0]  host_data_bus,
    input  wire logic [2:0]  host_addr,
    input  wire logic        front_end_clock,
    // loader outputs
    input  wire logic [7:0]  dest_addr,
    input  wire logic [31:0] dest_word,
    input  wire logic        front_load,
    input  wire logic        back_load,
    input  wire logic [31:0] gain_active,
    input  wire logic        gain_load,
    input  wire logic [31:0] carrier_active,
    input  wire logic        carrier_load,
    input  wire logic [2:0]  read_source
);
    logic [3:0] fe_age;
    logic [3:0] next_fe_age;
    logic       fe_q;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    // ==========================================================
    // helper: age of the last front domain clock rise
    always_comb
    begin
        next_fe_age = fe_age;
        if (front_end_clock && !fe_q)
            next_fe_age = 4'h0;
        else if (fe_age != 4'hf)
            next_fe_age = fe_age + 4'h1;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            fe_age <= 4'hf;
            fe_q   <= 1'b0;
        end
        else
        begin
            fe_age <= next_fe_age;
            fe_q   <= front_end_clock;
        end
    end

    // ==========================================================
    // assertions
    a_front_range: assert property (front_load |-> dest_addr <= 8'h0f)
        else $error("front load outside front destinations");
    a_back_range: assert property (back_load |-> dest_addr > 8'h0f)
        else $error("back load outside back destinations");
    a_load_single: assert property ((front_load || back_load)
        |=> !(front_load || back_load))
        else $error("load pulse longer than one cycle");
    a_word_hold: assert property (!(front_load || back_load)
        |-> $stable(dest_word) && $stable(dest_addr))
        else $error("destination changed without a load");
    a_front_edge: assert property (front_load |-> fe_age <= 4'h6)
        else $error("front load without a recent domain clock edge");
    a_gain_cause: assert property (!gain_load |-> $stable(gain_active))
        else $error("active gain changed without gain load");
    a_carrier_cause: assert property (!carrier_load
        |-> $stable(carrier_active))
        else $error("active carrier changed without carrier load");
    a_rdsel_cause: assert property ($changed(read_source)
        |-> host_addr == 3'h5 && read_source == host_data_bus[2:0])
        else $error("read source changed without a select write");

endmodule : icwl_loader_chk

bind icwl_loader icwl_loader_chk icwl_loader_chk_i (.clock, .rstn,
    .host_data_bus, .host_addr, .front_end_clock, .dest_addr, .dest_word,
    .front_load, .back_load, .gain_active, .gain_load, .carrier_active,
    .carrier_load, .read_source);

`default_nettype wire

// ===== verification/testbench.sv
// Purpose: self-checking bench of the control word loader
// Assumes: domain clocks made here, slower than clock/2
// Notes:   host writes go through the host model
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end

module testbench;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic        front_end_clock = 1'b0;
    logic        back_end_clock = 1'b0;
    logic        carrier_sync_in = 1'b0;
    logic        gain_sync_in = 1'b0;
    logic        fe_run = 1'b1;
    logic        seen;
    logic [1:0]  fe_div = 2'h0;
    logic [2:0]  be_div = 3'h0;
    int          fe_edges = 0;
    int          errors = 0;
    int          total_checks = 0;
    wire  [7:0]  host_data_bus;
    wire  [2:0]  host_addr;
    wire         write_strobe;
    logic [7:0]  dest_addr;
    logic [31:0] dest_word;
    logic        front_load;
    logic        back_load;
    logic [31:0] gain_active;
    logic        gain_load;
    logic [31:0] carrier_active;
    logic        carrier_load;
    logic [2:0]  read_source;

    icwl_host_model host_i (.clock(clock), .host_data_bus(host_data_bus),
        .host_addr(host_addr), .write_strobe(write_strobe));

    icwl_loader icwl_loader_i (.clock(clock), .rstn(rstn),
        .host_data_bus(host_data_bus), .host_addr(host_addr),
        .write_strobe(write_strobe), .front_end_clock(front_end_clock),
        .back_end_clock(back_end_clock), .carrier_sync_in(carrier_sync_in),
        .gain_sync_in(gain_sync_in), .dest_addr(dest_addr),
        .dest_word(dest_word), .front_load(front_load),
        .back_load(back_load), .gain_active(gain_active),
        .gain_load(gain_load), .carrier_active(carrier_active),
        .carrier_load(carrier_load), .read_source(read_source));

    // ==========================================================
    // clocks: front half period 4, back half period 8
    always #25 clock = ~clock;

    always @(posedge clock)
    begin
        if (fe_run)
            fe_div <= fe_div + 2'h1;
        if (fe_run && fe_div == 2'h3)
            front_end_clock <= ~front_end_clock;
        if (fe_run && fe_div == 2'h3 && !front_end_clock)
            fe_edges <= fe_edges + 1;
        be_div <= be_div + 3'h1;
        if (be_div == 3'h7)
            back_end_clock <= ~back_end_clock;
    end

    // ==========================================================
    // tasks
    task automatic results;
        if (errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results

    task automatic wait_load(input logic [7:0] dst, input logic [31:0] w);
        int n;
        n = 0;
        @(negedge clock);
        while (!(front_load || back_load) && n < 200)
        begin
            @(negedge clock);
            n++;
        end
        `CHECK(front_load, dst <= 8'h0f)
        `CHECK(back_load, dst > 8'h0f)
        `CHECK(dest_addr, dst)
        `CHECK(dest_word, w)
    endtask : wait_load

    task automatic put_word(input logic [31:0] w);
        host_i.write(3'h2, w[23:16]);
        host_i.write(3'h0, w[7:0]);
        host_i.write(3'h3, w[31:24]);
        host_i.write(3'h1, w[15:8]);
    endtask : put_word

    task automatic load(input logic [7:0] dst, input logic [31:0] w);
        put_word(w);
        host_i.write(3'h4, dst);
        wait_load(dst, w);
        repeat (4) @(posedge clock);
    endtask : load

    task automatic sync_pulse(input logic gain);
        int n;
        n = 0;
        @(posedge clock);
        gain_sync_in    <= gain;
        carrier_sync_in <= !gain;
        do
        begin
            @(negedge clock);
            n++;
        end while (!(gain ? gain_load : carrier_load) && n < 20);
        `CHECK(gain ? gain_load : carrier_load, 1'b1)
        @(posedge clock);
        gain_sync_in    <= 1'b0;
        carrier_sync_in <= 1'b0;
        repeat (4) @(posedge clock);
    endtask : sync_pulse

    // ==========================================================
    // tests
    initial
    begin
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        @(negedge clock);
        `CHECK(read_source, 3'h0)
        load(8'h00, 32'h0018_d038);
        load(8'h01, 32'h1234_5678);
        `CHECK(carrier_active, 32'h0)
        put_word(32'hdead_beef);
        sync_pulse(1'b0);
        `CHECK(carrier_active, 32'h1234_5678)
        load(8'h0b, 32'h0000_0a5a);
        `CHECK(gain_active, 32'h0000_0a5a)
        load(8'h08, 32'h2000_0000);
        load(8'h0b, 32'h0000_1111);
        `CHECK(gain_active, 32'h0000_0a5a)
        put_word(32'h0000_2222);
        sync_pulse(1'b1);
        `CHECK(gain_active, 32'h0000_2222)
        load(8'h0f, 32'hffff_ffff);
        load(8'h10, 32'h8000_0001);
        load(8'hff, 32'h0102_0304);
        host_i.write(3'h5, 8'hfe);
        `CHECK(read_source, 3'h6)
        host_i.write(3'h6, 8'h01);
        host_i.write(3'h7, 8'h02);
        `CHECK(read_source, 3'h6)
        host_i.write(3'h4, 8'h30);
        wait_load(8'h30, 32'h0102_0304);
        @(posedge clock);
        fe_run <= 1'b0;
        host_i.write(3'h4, 8'h02);
        seen = 1'b0;
        repeat (40)
        begin
            @(negedge clock);
            seen = seen | front_load | back_load;
        end
        `CHECK(seen, 1'b0)
        @(posedge clock);
        fe_edges <= 0;
        fe_run   <= 1'b1;
        wait_load(8'h02, 32'h0102_0304);
        `CHECK(fe_edges, 4)
        results();
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        errors++;
        results();
    end

endmodule : testbench

`default_nettype wire
